// *** logic/gic_pkg.sv ***
package gic_pkg;

    // Register map (byte addresses)
    localparam logic [31:0] GIC_BASE_ADDR     = 32'hd400_0000;
    localparam logic [31:0] GIC_ACCEPT_ADDR   = 32'hd400_0100;
    localparam logic [31:0] GIC_TRIG_ADDR     = 32'hd400_0200;
    localparam int          GIC_GROUP_STRIDE  = 4;

    // Group numbering
    localparam int          GIC_FIRST_GROUP   = 2;
    localparam int          GIC_LAST_GROUP    = 41;
    localparam int          GIC_FIRST_EXT     = 34;
    localparam int          GIC_NUM_PERIPH    = 32;
    localparam int          GIC_NUM_PINS      = 8;

    // Group control register fields
    localparam int          GIC_ACTIVE_BIT    = 0;
    localparam int          GIC_REQUEST_BIT   = 4;
    localparam int          GIC_ENABLE_BIT    = 8;
    localparam int          GIC_PRIO_LSB      = 12;
    localparam int          GIC_PRIO_MSB      = 14;

    // Accepted group register field
    localparam int          GIC_GN_LSB        = 2;
    localparam int          GIC_GN_MSB        = 7;

    // Trigger select field width per pin
    localparam int          GIC_TRIG_W        = 2;

    // Reset values
    localparam logic [2:0]  GIC_PRIO_RST      = 3'h0;
    localparam logic [5:0]  GIC_GN_RST        = 6'h00;
    localparam logic [15:0] GIC_TRIG_RST      = 16'h0000;

    typedef enum logic [1:0] {
        GIC_TRIG_LOW  = 2'h0,
        GIC_TRIG_HIGH = 2'h1,
        GIC_TRIG_FALL = 2'h2,
        GIC_TRIG_RISE = 2'h3
    } gic_trig_type;

    typedef struct packed {
        logic       irq;
        logic [2:0] level;
        logic       nmi;
    } gic_cpu_req_type;

endpackage

// *** logic/gic_pin_detect.sv ***
module gic_pin_detect (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // Pin and mode
    input  wire logic                  pin,
    input  wire gic_pkg::gic_trig_type trig,
    // Detection
    output logic                       hit
);
    import gic_pkg::*;

    logic sync1_r;
    logic sync2_r;
    logic prev_r;

    // Two-stage synchroniser, then one more stage for edges
    // Stages reset to the idle high level, so the default low-level
    // trigger sees no false request while the pipeline fills
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            prev_r  <= 1'b1;
        end else begin
            sync1_r <= pin;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    always_comb begin
        unique case (trig)
            GIC_TRIG_LOW:  hit = !sync2_r;
            GIC_TRIG_HIGH: hit = sync2_r;
            GIC_TRIG_FALL: hit = prev_r && !sync2_r;
            GIC_TRIG_RISE: hit = !prev_r && sync2_r;
        endcase
    end

endmodule // gic_pin_detect

// *** logic/gic_top.sv ***
// Contract
// - Priority in bits 14:12; request only when priority below CPU mask.
// - Enable in bit 8; enabling a pending request raises it immediately.
// - Request flag bit 4 latches source until software clears it.
// - Active flag bit 0 always reads enable AND request.
// - Write pair: active 0 no change; 1/0 clears; 1/1 sets request.
// - Reserved bits read zero and writes to them do nothing.
// - Control registers for groups 2 to 41, one word apart.
// - Accepted register bits 7:2 hold lowest pending group at mask level.
// - A lower pending group updates the accepted register before reading.
// - Pin trigger: 00 low, 01 high, 10 falling, 11 rising.
// - Trigger register packs pin k at bits 2k+1 to 2k.
// - Winning group drives CPU request with its level, number recorded.
// - Arbitration: smallest level value first, then smallest group number.
// - NMI pin, watchdog overflow, bus error go straight to CPU NMI.
// - External pins 0 to 7 feed groups 34 to 41 in order.
//
// Decided for this implementation: register access over APB.
module gic_top (
    // Clock and reset
    input  wire logic                     CLK_SYS,
    input  wire logic                     RST_N,
    // APB slave
    input  wire logic                     PSEL,
    input  wire logic                     PENABLE,
    input  wire logic                     PWRITE,
    input  wire logic [31:0]              PADDR,
    input  wire logic [31:0]              PWDATA,
    input  wire logic [3:0]               PSTRB,
    output logic                          PREADY,
    output logic [31:0]                   PRDATA,
    output logic                          PSLVERR,
    // Interrupt sources
    input  wire logic [31:0]              PERIPH_IRQ,
    input  wire logic [7:0]               EXT_IRQ,
    input  wire logic                     NMI_PIN_N,
    input  wire logic                     WDT_OVERFLOW,
    input  wire logic                     BUS_ERROR,
    // CPU side
    input  wire logic [2:0]               CPU_MASK_LEVEL,
    output gic_pkg::gic_cpu_req_type      CPU_REQ
);
    import gic_pkg::*;

    logic [2:0]          prio_r    [GIC_FIRST_GROUP:GIC_LAST_GROUP];
    logic                enable_r  [GIC_FIRST_GROUP:GIC_LAST_GROUP];
    logic                request_r [GIC_FIRST_GROUP:GIC_LAST_GROUP];
    logic                active    [GIC_FIRST_GROUP:GIC_LAST_GROUP];
    logic                src_evt   [GIC_FIRST_GROUP:GIC_LAST_GROUP];
    logic [15:0]         trig_r;
    logic [5:0]          accept_r;
    logic [7:0]          pin_hit;
    logic                grp_sel   [GIC_FIRST_GROUP:GIC_LAST_GROUP];
    logic                ctl_hit;
    logic                acc_hit;
    logic                trg_hit;
    logic [5:0]          addr_idx;
    logic                wr_en;
    logic                setup;
    logic [31:0]         rdata_nxt;
    logic                win_any;
    logic [2:0]          win_level;
    logic                acc_any;
    logic [5:0]          acc_num;
    gic_cpu_req_type     cpu_nxt;
    gic_cpu_req_type     cpu_r;

    // Address decode
    assign addr_idx = PADDR[7:2];
    assign ctl_hit  = (PADDR[31:8] == GIC_BASE_ADDR[31:8])
                      && (PADDR[1:0] == 2'h0)
                      && (addr_idx >= 6'(GIC_FIRST_GROUP))
                      && (addr_idx <= 6'(GIC_LAST_GROUP));
    assign acc_hit  = (PADDR == GIC_ACCEPT_ADDR);
    assign trg_hit  = (PADDR == GIC_TRIG_ADDR);
    assign setup    = PSEL && !PENABLE;
    assign wr_en    = PSEL && PENABLE && PWRITE;

    // Zero-wait slave
    assign PREADY   = PSEL && PENABLE;

    // External pin detectors, pin k on group 34+k
    for (genvar k = 0; k < GIC_NUM_PINS; k++) begin : g_pin
        gic_pin_detect u_det (
            .clk   (CLK_SYS),
            .rst_n (RST_N),
            .pin   (EXT_IRQ[k]),
            .trig  (gic_trig_type'(trig_r[GIC_TRIG_W*k +: GIC_TRIG_W])),
            .hit   (pin_hit[k])
        );
    end

    // Per-group source, selection and flags
    for (genvar g = GIC_FIRST_GROUP; g <= GIC_LAST_GROUP; g++) begin : g_grp
        if (g < GIC_FIRST_EXT) begin : g_periph
            assign src_evt[g] = PERIPH_IRQ[g - GIC_FIRST_GROUP];
        end else begin : g_ext
            assign src_evt[g] = pin_hit[g - GIC_FIRST_EXT];
        end

        assign grp_sel[g] = ctl_hit && (addr_idx == 6'(g));
        assign active[g]  = enable_r[g] && request_r[g];

        // Priority and enable in byte 1 (bits 15:8), written under PSTRB[1]
        always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
                prio_r[g]   <= GIC_PRIO_RST;
                enable_r[g] <= 1'b0;
            end else if (wr_en && grp_sel[g] && PSTRB[1]) begin
                prio_r[g]   <= PWDATA[GIC_PRIO_MSB:GIC_PRIO_LSB];
                enable_r[g] <= PWDATA[GIC_ENABLE_BIT];
            end
        end

        // Request flag: a source event wins over a software clear
        always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
                request_r[g] <= 1'b0;
            end else if (src_evt[g]) begin
                request_r[g] <= 1'b1;
            end else if (wr_en && grp_sel[g] && PSTRB[0]
                         && PWDATA[GIC_ACTIVE_BIT]) begin
                request_r[g] <= PWDATA[GIC_REQUEST_BIT];
            end
        end
    end

    // Trigger configuration
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            trig_r <= GIC_TRIG_RST;
        end else if (wr_en && trg_hit) begin
            if (PSTRB[0]) begin
                trig_r[7:0] <= PWDATA[7:0];
            end
            if (PSTRB[1]) begin
                trig_r[15:8] <= PWDATA[15:8];
            end
        end
    end

    // Arbitration over enabled pending groups
    always_comb begin
        win_any   = 1'b0;
        win_level = 3'h0;
        for (int g = GIC_FIRST_GROUP; g <= GIC_LAST_GROUP; g++) begin
            if (active[g] && (prio_r[g] < CPU_MASK_LEVEL)
                && (!win_any || (prio_r[g] < win_level))) begin
                win_any   = 1'b1;
                win_level = prio_r[g];
            end
        end
    end

    // Lowest pending group at the level the CPU mask shows
    always_comb begin
        acc_any = 1'b0;
        acc_num = GIC_GN_RST;
        for (int g = GIC_LAST_GROUP; g >= GIC_FIRST_GROUP; g--) begin
            if (request_r[g] && enable_r[g]
                && (prio_r[g] == CPU_MASK_LEVEL)) begin
                acc_any = 1'b1;
                acc_num = 6'(g);
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            accept_r <= GIC_GN_RST;
        end else if (acc_any) begin
            accept_r <= acc_num;
        end
    end

    // CPU request, level and NMI
    always_comb begin
        cpu_nxt.irq   = win_any;
        cpu_nxt.level = win_level;
        cpu_nxt.nmi   = !NMI_PIN_N || WDT_OVERFLOW || BUS_ERROR;
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            cpu_r <= '0;
        end else begin
            cpu_r <= cpu_nxt;
        end
    end

    assign CPU_REQ = cpu_r;

    // Read data captured in the setup cycle; reserved bits are zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        for (int g = GIC_FIRST_GROUP; g <= GIC_LAST_GROUP; g++) begin
            if (grp_sel[g]) begin
                rdata_nxt[GIC_PRIO_MSB:GIC_PRIO_LSB] = prio_r[g];
                rdata_nxt[GIC_ENABLE_BIT]  = enable_r[g];
                rdata_nxt[GIC_REQUEST_BIT] = request_r[g];
                rdata_nxt[GIC_ACTIVE_BIT]  = active[g];
            end
        end
        if (acc_hit) begin
            rdata_nxt[GIC_GN_MSB:GIC_GN_LSB] = accept_r;
        end
        if (trg_hit) begin
            rdata_nxt[15:0] = trig_r;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            PRDATA <= 32'h0000_0000;
        end else if (setup) begin
            PRDATA <= PWRITE ? 32'h0000_0000 : rdata_nxt;
        end
    end

    // Unmapped addresses and writes to the read-only register
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            PSLVERR <= 1'b0;
        end else if (setup) begin
            PSLVERR <= !(ctl_hit || trg_hit || (acc_hit && !PWRITE));
        end
    end

endmodule // gic_top

// *** verification/gic_chk.sv ***
module gic_chk
    import gic_pkg::*;
(
    // Clock and reset
    input wire logic            CLK_SYS,
    input wire logic            RST_N,
    // Register bus
    input wire logic            PSEL,
    input wire logic            PENABLE,
    input wire logic            PWRITE,
    input wire logic [31:0]     PADDR,
    input wire logic [31:0]     PRDATA,
    input wire logic            PSLVERR,
    // Sources and CPU
    input wire logic            NMI_PIN_N,
    input wire logic            WDT_OVERFLOW,
    input wire logic            BUS_ERROR,
    input wire logic [2:0]      CPU_MASK_LEVEL,
    input wire gic_cpu_req_type CPU_REQ
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    wire logic rd_ok = PSEL && PENABLE && !PWRITE && !PSLVERR;
    wire logic nmi_any = !NMI_PIN_N || WDT_OVERFLOW || BUS_ERROR;
    property p_nmi_on; nmi_any |=> CPU_REQ.nmi; endproperty
    a_nmi_on: assert property (p_nmi_on)
        else $error("nmi not raised");
    property p_nmi_off; !nmi_any |=> !CPU_REQ.nmi; endproperty
    a_nmi_off: assert property (p_nmi_off)
        else $error("nmi raised without source");
    property p_mask;
        CPU_REQ.irq |-> CPU_REQ.level < $past(CPU_MASK_LEVEL);
    endproperty
    a_mask: assert property (p_mask)
        else $error("request level not below mask");
    property p_rsv;
        rd_ok && PADDR < GIC_ACCEPT_ADDR |-> (PRDATA & 32'hffff8eee) == 0;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved control bits nonzero");
    property p_act;
        rd_ok && PADDR < GIC_ACCEPT_ADDR |-> PRDATA[0] == (PRDATA[8] & PRDATA[4]);
    endproperty
    a_act: assert property (p_act)
        else $error("active flag mismatch");
    property p_agr;
        rd_ok && PADDR == GIC_ACCEPT_ADDR
            |-> PRDATA[31:8] == 0 && PRDATA[1:0] == 0 && PRDATA[7:2] <= 6'h29;
    endproperty
    a_agr: assert property (p_agr)
        else $error("accepted group value bad");
    property p_trg; rd_ok && PADDR == GIC_TRIG_ADDR |-> PRDATA[31:16] == 0;
    endproperty
    a_trg: assert property (p_trg)
        else $error("trigger upper bits nonzero");
    property p_g0; PSEL && PENABLE && PADDR == GIC_BASE_ADDR |-> PSLVERR;
    endproperty
    a_g0: assert property (p_g0)
        else $error("group 0 access accepted");
endmodule // gic_chk

bind gic_top gic_chk u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
    .PSLVERR(PSLVERR), .NMI_PIN_N(NMI_PIN_N), .WDT_OVERFLOW(WDT_OVERFLOW),
    .BUS_ERROR(BUS_ERROR), .CPU_MASK_LEVEL(CPU_MASK_LEVEL), .CPU_REQ(CPU_REQ));

// *** verification/gic_ext_src.sv ***
module gic_ext_src (
    // Clock
    input wire logic  clk,
    // Request pins
    output logic [7:0] ext
);
    timeunit 1ns;
    timeprecision 1ps;
    initial ext = 8'hff;
    // Every pin state is held three clocks so the synchroniser sees it
    task automatic hold(input int k, input logic v);
        @(posedge clk);
        ext[k] <= v;
        repeat (3) @(posedge clk);
    endtask
endmodule // gic_ext_src

// *** verification/gic_top_tb_top.sv ***
module gic_top_tb_top;
    import gic_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic            clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0]     paddr = 0, pwdata = 0, periph = 0, rdat, prdata;
    logic [2:0]      mask = 3'h7, nmi_src = 3'h0;
    logic [7:0]      ext;
    logic            pready, pslverr, slverr;
    gic_cpu_req_type req;
    int              mismatches = 0, comparisons = 0;
    always #5 clk = ~clk;
    gic_ext_src u_src (.clk(clk), .ext(ext));
    gic_top u_dut (.CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PSTRB(4'hf), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
        .PERIPH_IRQ(periph), .EXT_IRQ(ext), .NMI_PIN_N(~nmi_src[0]),
        .WDT_OVERFLOW(nmi_src[1]), .BUS_ERROR(nmi_src[2]),
        .CPU_MASK_LEVEL(mask), .CPU_REQ(req));
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        slverr = pslverr;
        if (n >= 20) begin
            mismatches++;
            report_and_stop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [31:0] ga(int n);
        return GIC_BASE_ADDR + 32'(4 * n);
    endfunction
    task automatic rdc(input logic [31:0] a, e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rdat);
    endtask
    task automatic req_chk(input logic [4:0] e);
        repeat (3) @(posedge clk);
        chk("cpu request", {27'h0, e}, {27'h0, req});
    endtask
    task automatic pulse(input logic [31:0] v);
        periph <= v;
        @(posedge clk);
        periph <= 32'h0;
    endtask
    task automatic t_reset;
        rdc(ga(2), 32'h0);
        rdc(ga(41), 32'h0);
        rdc(GIC_ACCEPT_ADDR, 32'h0);
        rdc(GIC_TRIG_ADDR, 32'h0);
        apb(1'b0, ga(0), 32'h0);
        chk("group 0 error", 32'h1, {31'h0, slverr});
        apb(1'b1, GIC_ACCEPT_ADDR, 32'hfc);
        chk("accepted write error", 32'h1, {31'h0, slverr});
        rdc(GIC_ACCEPT_ADDR, 32'h0);
    endtask
    task automatic t_flags;
        apb(1'b1, ga(5), 32'hffff);
        rdc(ga(5), 32'h7111);
        apb(1'b1, ga(5), 32'h7110);
        rdc(ga(5), 32'h7111);
        apb(1'b1, ga(5), 32'h7101);
        rdc(ga(5), 32'h7100);
        apb(1'b1, ga(5), 32'h0);
    endtask
    task automatic t_enable;
        pulse(32'h20);
        req_chk(5'h00);
        rdc(ga(7), 32'h0010);
        apb(1'b1, ga(7), 32'h0100);
        req_chk(5'h10);
        rdc(ga(7), 32'h0111);
        apb(1'b1, ga(7), 32'h0101);
        req_chk(5'h00);
    endtask
    task automatic t_arb;
        int g[4] = '{2, 3, 4, 6};
        for (int i = 0; i < 4; i++)
            apb(1'b1, ga(g[i]), g[i] == 3 ? 32'h2100 : 32'h1100);
        pulse(32'h16);
        req_chk(5'h12);
        mask <= 3'h1;
        req_chk(5'h00);
        rdc(GIC_ACCEPT_ADDR, 32'h10);
        pulse(32'h1);
        repeat (2) @(posedge clk);
        rdc(GIC_ACCEPT_ADDR, 32'h08);
        for (int i = 0; i < 4; i++)
            apb(1'b1, ga(g[i]), 32'h1);
        mask <= 3'h7;
    endtask
    task automatic t_ext;
        int p;
        for (int m = 0; m < 4; m++) begin
            p = 2 * m + 1;
            apb(1'b1, GIC_TRIG_ADDR, 32'(m) << (2 * p));
            rdc(GIC_TRIG_ADDR, 32'(m) << (2 * p));
            u_src.hold(p, ~m[0]);
            apb(1'b1, ga(34 + p), 32'h1);
            rdc(ga(34 + p), 32'h0);
            u_src.hold(p, m[0]);
            u_src.hold(p, ~m[0]);
            rdc(ga(34 + p), 32'h10);
        end
        apb(1'b1, GIC_TRIG_ADDR, 32'h0);
    endtask
    task automatic t_nmi;
        for (int i = 0; i < 3; i++) begin
            nmi_src <= 3'(1 << i);
            repeat (2) @(posedge clk);
            chk("nmi", 32'h1, {31'h0, req.nmi});
            nmi_src <= 3'h0;
            repeat (2) @(posedge clk);
            chk("nmi", 32'h0, {31'h0, req.nmi});
        end
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        $display("test reset done");
        t_flags();
        $display("test flags done");
        t_enable();
        $display("test enable done");
        t_arb();
        $display("test arbitration done");
        t_ext();
        $display("test external pins done");
        t_nmi();
        $display("test nmi done");
        report_and_stop();
    end
endmodule // gic_top_tb_top
